// File: verilog/dil_pkg.sv
package dil_pkg;
	// Sample word layout
	localparam int SAMPLE_W = 8;
	localparam int LSB_POS = 0;
	localparam int MSB_POS = 7;
	localparam int BIN_BITS = 2;
	localparam int UNARY_BITS = 6;
	localparam int UNARY_CELLS = 63;
	// Buffer and reset values
	localparam int BUF_DEPTH = 2;
	localparam logic [7:0] CODE_ZERO = 8'h00;
	// Data clock limits from the source
	localparam real DCLK_MIN_KHZ = 100.0;
	localparam real DCLK_MAX_MHZ = 40.0;
	localparam real DCLK_PW_NS = 12.5;
	localparam real MCLK_NS = 10.0;
	localparam int DCLK_PW_CYC = $rtoi((DCLK_PW_NS + MCLK_NS - 0.001) / MCLK_NS);

	// Drive to the current cells
	typedef struct packed {
		logic [UNARY_CELLS-1:0] unary;
		logic [BIN_BITS-1:0] binary;
	} dil_cells_s;
endpackage

// File: verilog/dil_input_latch.sv
`timescale 1ns/1ps
// Operation
// - The sample word is 8 bits wide, bit 0 least and bit 7 most significant.
// - High blanking forces the held code to zero; low blanking runs normally.
// - The latch holds its code unchanged while the data clock is high.
// - Low blanking lets the data clock update the latch; high clears it.
module dil_input_latch #(
	parameter int DEPTH = dil_pkg::BUF_DEPTH
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Sample source
	input wire logic [dil_pkg::SAMPLE_W-1:0] sample_i,
	input wire logic data_clk_i,
	input wire logic blanking_clear_i,
	output logic in_rdy_o,
	// Current cell side
	input wire logic cell_rdy_i,
	output logic code_vld_o,
	output logic [dil_pkg::SAMPLE_W-1:0] code_o,
	output dil_pkg::dil_cells_s cells_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [dil_pkg::SAMPLE_W-1:0] latch_ff;
	logic dclk_q_ff;
	logic [dil_pkg::SAMPLE_W-1:0] buf_ff [DEPTH];
	logic [PW-1:0] wr_ff;
	logic [PW-1:0] rd_ff;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic push;
	logic pop;
	wire logic sample_lsb = sample_i[dil_pkg::LSB_POS];
	wire logic sample_msb = sample_i[dil_pkg::MSB_POS];

	function automatic dil_pkg::dil_cells_s cell_decode(
		input logic [dil_pkg::SAMPLE_W-1:0] code
	);
		dil_pkg::dil_cells_s c;
		logic [dil_pkg::UNARY_BITS-1:0] hi;
		c.binary = code[dil_pkg::BIN_BITS-1:0];
		hi = code[dil_pkg::MSB_POS:dil_pkg::BIN_BITS];
		for (int i = 0; i < dil_pkg::UNARY_CELLS; i++) begin
			c.unary[i] = (hi > dil_pkg::UNARY_BITS'(i));
		end
		return c;
	endfunction

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// Closing edge of the latch hands its code to the buffer
	assign push = data_clk_i & ~dclk_q_ff & ~blanking_clear_i & in_rdy_o;
	assign pop = (cnt_ff != '0) & (~code_vld_o | cell_rdy_i)
		& ~blanking_clear_i;
	assign nxt_cnt = blanking_clear_i ? '0
		: CW'(cnt_ff + CW'(push) - CW'(pop));

	// Input latch
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			latch_ff <= dil_pkg::CODE_ZERO;
		end else if (ce_i) begin
			if (blanking_clear_i) begin
				latch_ff <= dil_pkg::CODE_ZERO;
			end else if (!data_clk_i) begin
				latch_ff <= {sample_msb, sample_i[6:1], sample_lsb};
			end
		end
	end

	// Data clock history
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			dclk_q_ff <= 1'b0;
		end else if (ce_i) begin
			dclk_q_ff <= data_clk_i;
		end
	end

	// Buffer storage
	always_ff @(posedge mclk_i) begin
		if (ce_i && push) begin
			buf_ff[wr_ff] <= latch_ff;
		end
	end

	// Buffer pointers and fill
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			in_rdy_o <= 1'b1;
		end else if (ce_i) begin
			if (blanking_clear_i) begin
				wr_ff <= '0;
				rd_ff <= '0;
			end else begin
				if (push) begin
					wr_ff <= ptr_inc(wr_ff);
				end
				if (pop) begin
					rd_ff <= ptr_inc(rd_ff);
				end
			end
			cnt_ff <= nxt_cnt;
			in_rdy_o <= (nxt_cnt != CW'(DEPTH));
		end
	end

	// Held code and cell drive
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			code_o <= dil_pkg::CODE_ZERO;
			cells_o <= '0;
			code_vld_o <= 1'b0;
		end else if (ce_i) begin
			if (blanking_clear_i) begin
				code_o <= dil_pkg::CODE_ZERO;
				cells_o <= '0;
				code_vld_o <= 1'b0;
			end else if (pop) begin
				code_o <= buf_ff[rd_ff];
				cells_o <= cell_decode(buf_ff[rd_ff]);
				code_vld_o <= 1'b1;
			end else if (cell_rdy_i) begin
				code_vld_o <= 1'b0;
			end
		end
	end

	property p_blank_zero;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && blanking_clear_i) |=> (code_o == 8'h00 && latch_ff == 8'h00
			&& cells_o == '0);
	endproperty
	a_blank_zero: assert property (p_blank_zero)
		else $error("blanking did not clear the code");

	property p_hold_high;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && data_clk_i && !blanking_clear_i) |=> $stable(latch_ff);
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("latch changed while data clock high");

	property p_follow_low;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && !data_clk_i && !blanking_clear_i)
			|=> (latch_ff == $past(sample_i));
	endproperty
	a_follow_low: assert property (p_follow_low)
		else $error("latch did not follow the sample");

	property p_cells_match;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(code_o[7:2] == 6'h00) |-> (cells_o.unary == '0
			&& cells_o.binary == code_o[1:0]);
	endproperty
	a_cells_match: assert property (p_cells_match)
		else $error("cell drive disagrees with zero code");

	property p_through;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && push && cnt_ff == '0 && !code_vld_o)
			##1 (ce_i && !blanking_clear_i)
			|=> (code_o == $past(latch_ff, 2) && code_vld_o);
	endproperty
	a_through: assert property (p_through)
		else $error("latched code not delivered in two cycles");

	property p_blank_drop;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && blanking_clear_i) |=> (!code_vld_o && cnt_ff == '0
			&& in_rdy_o);
	endproperty
	a_blank_drop: assert property (p_blank_drop)
		else $error("blanking left a word pending");

	property p_cells_count;
		@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |-> ($countones(cells_o.unary) == int'(code_o[7:2])
			&& cells_o.binary == code_o[1:0]);
	endproperty
	a_cells_count: assert property (p_cells_count)
		else $error("cell drive does not match the code");

	property p_cells_thermo;
		@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |-> ((cells_o.unary & (cells_o.unary + 1'b1)) == '0);
	endproperty
	a_cells_thermo: assert property (p_cells_thermo)
		else $error("unary cells not a thermometer code");

	property p_vld_hold;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && code_vld_o && !cell_rdy_i && !blanking_clear_i)
			|=> (code_vld_o && $stable(code_o));
	endproperty
	a_vld_hold: assert property (p_vld_hold)
		else $error("held code changed while stalled");

	property p_vld_clear;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && code_vld_o && cell_rdy_i && !pop && !blanking_clear_i)
			|=> !code_vld_o;
	endproperty
	a_vld_clear: assert property (p_vld_clear)
		else $error("accepted code stayed valid");

	property p_push_count;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && push && !pop) |=> (cnt_ff == $past(cnt_ff) + 1'b1);
	endproperty
	a_push_count: assert property (p_push_count)
		else $error("pushed word not counted");

	property p_rdy_track;
		@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |-> (in_rdy_o == (cnt_ff != CW'(DEPTH)));
	endproperty
	a_rdy_track: assert property (p_rdy_track)
		else $error("input ready disagrees with fill level");

	property p_freeze;
		@(posedge mclk_i) disable iff (sys_rst_i)
		!ce_i |=> ($stable(latch_ff) && $stable(code_o)
			&& $stable(cnt_ff));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while enable low");
endmodule // dil_input_latch

// File: verification/dil_src.sv
`timescale 1ns/1ps
module dil_src (
	// Source side
	input wire logic mclk_i,
	input wire logic in_rdy_i,
	output logic data_clk_o,
	output logic [7:0] sample_o
);
	initial begin
		data_clk_o = 1'b0;
		sample_o = 8'h00;
	end
	// One word, clock low at least two cycles (longer while in_rdy_i is low), then high two cycles
	task automatic send(input logic [7:0] w);
		sample_o = w;
		repeat (dil_pkg::DCLK_PW_CYC) @(negedge mclk_i);
		while (in_rdy_i !== 1'b1) @(negedge mclk_i);
		data_clk_o = 1'b1;
		@(negedge mclk_i);
		sample_o = ~w;
		@(negedge mclk_i);
		data_clk_o = 1'b0;
	endtask
endmodule // dil_src

// File: verification/dil_input_latch_bench.sv
`timescale 1ns/1ps
module dil_input_latch_bench;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic blank = 1'b0;
	logic ce = 1'b1;
	logic cell_rdy = 1'b1;
	logic dclk, rdy, vld;
	logic [7:0] smp, code;
	dil_pkg::dil_cells_s cells;
	int miscompares = 0;
	int check_count = 0;
	always #5 mclk_i = ~mclk_i;
	dil_src src (.mclk_i(mclk_i), .in_rdy_i(rdy), .data_clk_o(dclk),
		.sample_o(smp));
	dil_input_latch uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce), .sample_i(smp), .data_clk_i(dclk),
		.blanking_clear_i(blank), .in_rdy_o(rdy), .cell_rdy_i(cell_rdy),
		.code_vld_o(vld), .code_o(code), .cells_o(cells));
	task automatic chk(input string n, input logic [64:0] e,
		input logic [64:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wait_vld();
		int i;
		for (i = 0; i < 20 && vld !== 1'b1; i++) @(negedge mclk_i);
		chk("code_vld", 1, vld);
	endtask
	task automatic t_reset();
		chk("code", 0, code);
		chk("code_vld", 0, vld);
		chk("in_rdy", 1, rdy);
	endtask
	task automatic t_word();
		src.send(8'h81);
		wait_vld();
		chk("code", 8'h81, code);
		chk("cells", {31'h0, 32'hffffffff, 2'h1}, cells);
	endtask
	task automatic t_stall();
		repeat (2) @(negedge mclk_i);
		cell_rdy = 1'b0;
		src.send(8'ha5);
		src.send(8'h3c);
		wait_vld();
		chk("code", 8'ha5, code);
		chk("cells", {22'h0, 41'h1ffffffffff, 2'h1}, cells);
		src.send(8'hc3);
		chk("in_rdy", 0, rdy);
		chk("code", 8'ha5, code);
		cell_rdy = 1'b1;
		@(negedge mclk_i);
		chk("code", 8'h3c, code);
		@(negedge mclk_i);
		chk("code", 8'hc3, code);
	endtask
	task automatic t_blank();
		cell_rdy = 1'b0;
		src.send(8'h55);
		blank = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("code", 0, code);
		chk("cells", 0, cells);
		chk("code_vld", 0, vld);
		chk("in_rdy", 1, rdy);
		blank = 1'b0;
		cell_rdy = 1'b1;
		repeat (3) @(negedge mclk_i);
		chk("code_vld", 0, vld);
		src.send(8'h02);
		wait_vld();
		chk("code", 8'h02, code);
	endtask
	task automatic t_freeze();
		repeat (2) @(negedge mclk_i);
		ce = 1'b0;
		src.send(8'h77);
		repeat (2) @(negedge mclk_i);
		chk("code_vld", 0, vld);
		chk("code", 8'h02, code);
		ce = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk("code_vld", 0, vld);
	endtask
	task automatic t_rerun();
		cell_rdy = 1'b0;
		src.send(8'h99);
		wait_vld();
		chk("code", 8'h99, code);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		cell_rdy = 1'b1;
		t_reset();
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		t_reset();
		t_word();
		t_stall();
		t_blank();
		t_freeze();
		t_rerun();
		tally_and_finish();
	end
endmodule // dil_input_latch_bench
